//--- logic/srap_pkg.sv
package srap_pkg;

  // frame geometry
  localparam int INSTR_BITS   = 16;
  localparam int BYTE_BITS    = 8;
  localparam int SCLK_MAX_MHZ = 100;

  // register map
  localparam int         REG_COUNT      = 8;
  localparam int         TUNING_BYTES   = 6;
  localparam logic [14:0] ADDR_CONFIG    = 15'h0000;
  localparam logic [14:0] ADDR_TUNING_LO = 15'h0001;
  localparam logic [14:0] ADDR_LOAD_CTRL = 15'h0007;

  // values after reset
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET   = 8'h00;

  // config field positions, upper nibble and its mirror
  localparam int CFG_SOFT_RESET_HI = 7;
  localparam int CFG_LSB_FIRST_HI  = 6;
  localparam int CFG_ADDR_UP_HI    = 5;
  localparam int CFG_OUT_ACTIVE_HI = 4;
  localparam int CFG_OUT_ACTIVE_LO = 3;
  localparam int CFG_ADDR_UP_LO    = 2;
  localparam int CFG_LSB_FIRST_LO  = 1;
  localparam int CFG_SOFT_RESET_LO = 0;
  localparam int LOAD_REQ_BIT      = 0;

  typedef struct packed {
    logic soft_reset;
    logic lsb_first;
    logic addr_step_up;
    logic out_active;
  } srap_cfg_t;

  typedef struct packed {
    logic sdio_out;
    logic sdio_oe;
    logic serial_out_line;
    logic sdo_oe;
  } srap_drive_t;

endpackage : srap_pkg

//--- logic/srap_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser; first stage feeds only the second
module srap_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } srap_sync_t;

  srap_sync_t st;
  srap_sync_t next_st;

  // shift the level through both stages
  always_comb begin
    next_st.meta   = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;

endmodule : srap_sync

//--- logic/srap_port.sv
`timescale 1ns/1ps
// serial register port: link logic on SCLK, tuning word output on CLK
module srap_port #(
  parameter int REG_COUNT = srap_pkg::REG_COUNT
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SDIO_IN,
  output logic             SDIO_OUT,
  output logic             SDIO_OE,
  output logic             SERIAL_OUT_LINE,
  output logic             SERIAL_OUT_LINE_OE,
  output logic [47:0]      FREQUENCY_TUNING_WORD
);

  localparam int IDX_W = $clog2(REG_COUNT);
  localparam logic [IDX_W-1:0] CFG_IDX    = srap_pkg::ADDR_CONFIG[IDX_W-1:0];
  localparam logic [IDX_W-1:0] TUNING_IDX = srap_pkg::ADDR_TUNING_LO[IDX_W-1:0];

  // per-frame state, cleared whenever chip select is high
  typedef struct packed {
    logic        data_phase;
    logic        halt;
    logic        rw;
    logic [4:0]  count;
    logic [2:0]  bit_idx;
    logic [14:0] addr;
    logic [15:0] shift;
  } srap_frame_t;

  // register bank plus the tuning word handover, cleared only by reset
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic                      req_tog;
    logic [47:0]               hold;
  } srap_bank_t;

  // CLK-side state
  typedef struct packed {
    logic        req_seen;
    logic [47:0] word;
  } srap_core_t;

  logic                 rst_n;
  logic                 frame_rst_n;
  logic                 req_sync;
  logic                 ack_sync;
  logic                 pending;
  logic [15:0]          shift_in;
  logic [7:0]           byte_in;
  logic [7:0]           rd_byte;
  logic                 in_range;
  logic [IDX_W-1:0]     idx;
  logic [47:0]          tuning_shadow;
  srap_pkg::srap_cfg_t  cfg;
  srap_pkg::srap_cfg_t  nib;
  srap_frame_t          frame;
  srap_frame_t          next_frame;
  srap_bank_t           bank;
  srap_bank_t           next_bank;
  srap_core_t           core;
  srap_core_t           next_core;
  srap_pkg::srap_drive_t drive;
  srap_pkg::srap_drive_t next_drive;

  // reset release through two flops on CLK
  srap_sync #(
    .W (1)
  ) u_rst_sync (
    .clk   (CLK),
    .rst_n (ARST_N),
    .d     (1'b1),
    .q     (rst_n)
  );

  // chip select high ends the frame; a short high pulse is enough to restart
  assign frame_rst_n = rst_n & ~CS_N;

  // live configuration, upper nibble holds the working copy
  assign cfg.soft_reset   = bank.regs[CFG_IDX][srap_pkg::CFG_SOFT_RESET_HI];
  assign cfg.lsb_first    = bank.regs[CFG_IDX][srap_pkg::CFG_LSB_FIRST_HI];
  assign cfg.addr_step_up = bank.regs[CFG_IDX][srap_pkg::CFG_ADDR_UP_HI];
  assign cfg.out_active   = bank.regs[CFG_IDX][srap_pkg::CFG_OUT_ACTIVE_HI];

  // LSB first shifts right so both orders land in the same layout
  assign shift_in = cfg.lsb_first ? {SDIO_IN, frame.shift[15:1]}
                                  : {frame.shift[14:0], SDIO_IN};
  assign byte_in  = cfg.lsb_first ? shift_in[15:8] : shift_in[7:0];

  assign idx      = frame.addr[IDX_W-1:0];
  assign in_range = frame.addr < 15'(REG_COUNT);
  assign pending  = bank.req_tog ^ ack_sync;

  // first nibble of a config byte, same field order in both bit orders
  assign nib = cfg.lsb_first ? {byte_in[0], byte_in[1], byte_in[2], byte_in[3]}
                             : byte_in[7:4];

  // tuning word shadow bytes, least significant at the lowest address
  for (genvar i = 0; i < srap_pkg::TUNING_BYTES; i++) begin : g_tuning
    assign tuning_shadow[8*i +: 8] = bank.regs[TUNING_IDX + IDX_W'(i)];
  end

  // read data selection; unmapped addresses read zero
  always_comb begin
    if (frame.addr == srap_pkg::ADDR_LOAD_CTRL) begin
      rd_byte = {7'h00, pending};
    end else if (in_range) begin
      rd_byte = bank.regs[idx];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // bit engine on the rising SCLK edge
  always_comb begin
    next_frame = frame;
    next_bank  = bank;
    if (!frame.halt) begin
      next_frame.shift = shift_in;
      if (!frame.data_phase) begin
        next_frame.count = frame.count + 5'h01;
        if (frame.count == 5'(srap_pkg::INSTR_BITS - 1)) begin
          next_frame.data_phase = 1'b1;
          next_frame.rw         = shift_in[15];
          next_frame.addr       = shift_in[14:0];
          next_frame.bit_idx    = 3'h0;
        end
      end else begin
        next_frame.bit_idx = frame.bit_idx + 3'h1;
        if (frame.bit_idx == 3'(srap_pkg::BYTE_BITS - 1)) begin
          // byte complete: commit a write at once
          if (!frame.rw) begin
            if (frame.addr == srap_pkg::ADDR_CONFIG) begin
              if (nib.soft_reset) begin
                // defaults back; hold and toggle survive so the handshake stays sane
                for (int r = 0; r < REG_COUNT; r++) begin
                  next_bank.regs[r] = srap_pkg::BYTE_RESET;
                end
                next_bank.regs[CFG_IDX] = srap_pkg::CONFIG_RESET;
                next_frame.halt = 1'b1;
              end else begin
                next_bank.regs[CFG_IDX] = {1'b0, nib.lsb_first, nib.addr_step_up,
                                           nib.out_active, nib.out_active,
                                           nib.addr_step_up, nib.lsb_first,
                                           1'b0};
              end
            end else if (frame.addr == srap_pkg::ADDR_LOAD_CTRL) begin
              // request taken only when the previous one has been consumed
              if (byte_in[srap_pkg::LOAD_REQ_BIT] && !pending) begin
                next_bank.req_tog = ~bank.req_tog;
                next_bank.hold    = tuning_shadow;
              end
            end else if (in_range) begin
              next_bank.regs[idx] = byte_in;
            end
          end
          // step the address for the next byte, wrapping in 15 bits
          if (cfg.addr_step_up) begin
            next_frame.addr = frame.addr + 15'h0001;
          end else begin
            next_frame.addr = frame.addr - 15'h0001;
          end
        end
      end
    end
  end

  always_ff @(posedge SCLK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  always_ff @(posedge SCLK or negedge rst_n) begin
    if (!rst_n) begin
      bank                   <= '0;
      bank.regs[CFG_IDX]     <= srap_pkg::CONFIG_RESET;
    end else begin
      bank <= next_bank;
    end
  end

  // read bits leave on the falling edge, only once the instruction is in
  always_comb begin
    logic bit_out;
    bit_out    = 1'b0;
    next_drive = '0;
    if (frame.data_phase && frame.rw && !frame.halt) begin
      bit_out = rd_byte[cfg.lsb_first ? frame.bit_idx : 3'h7 - frame.bit_idx];
      if (cfg.out_active) begin
        next_drive.serial_out_line    = bit_out;
        next_drive.sdo_oe = 1'b1;
      end else begin
        next_drive.sdio_out = bit_out;
        next_drive.sdio_oe  = 1'b1;
      end
    end
  end

  // chip select high releases the pins without waiting for a clock edge
  always_ff @(negedge SCLK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  // load request toggle into CLK, acknowledge toggle back into SCLK
  srap_sync #(
    .W (1)
  ) u_req_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     (bank.req_tog),
    .q     (req_sync)
  );

  // ack advances only on SCLK edges, so pending clears during the next frame
  srap_sync #(
    .W (1)
  ) u_ack_sync (
    .clk   (SCLK),
    .rst_n (rst_n),
    .d     (core.req_seen),
    .q     (ack_sync)
  );

  // hold stays still until acknowledged, so it is safe to sample here
  always_comb begin
    next_core = core;
    if (req_sync != core.req_seen) begin
      next_core.req_seen = req_sync;
      next_core.word     = bank.hold;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  assign SDIO_OUT              = drive.sdio_out;
  assign SDIO_OE               = drive.sdio_oe;
  assign SERIAL_OUT_LINE       = drive.serial_out_line;
  assign SERIAL_OUT_LINE_OE    = drive.sdo_oe;
  assign FREQUENCY_TUNING_WORD = core.word;

endmodule : srap_port

//--- tb/srap_port_assertions.sv
`timescale 1ns/1ps
// port checks: in-frame drive on SCLK; idle pins, frame start and tuning word on CLK
module srap_port_checker (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        SCLK,
  input wire logic        CS_N,
  input wire logic        SDIO_OE,
  input wire logic        SERIAL_OUT_LINE_OE,
  input wire logic [47:0] FREQUENCY_TUNING_WORD
);
  logic [7:0] edges;
  logic [3:0] quiet;
  // rising edges in frame; saturates so long frames never wrap
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) edges <= 8'h00;
    else if (edges != 8'hff) edges <= edges + 8'h01;
  end
  // clk cycles since chip select was last low
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) quiet <= 4'hf;
    else if (!CS_N) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  sequence s_open; $fell(CS_N); endsequence
  sequence s_shut; (!SDIO_OE && !SERIAL_OUT_LINE_OE) [*8]; endsequence
  property p_idle; @(posedge CLK) disable iff (!ARST_N)
    CS_N && $past(CS_N) |-> !SDIO_OE; endproperty
  a_idle: assert property (p_idle) else $error("pin driven idle");
  property p_idle4; @(posedge CLK) disable iff (!ARST_N)
    CS_N && $past(CS_N) |-> !SERIAL_OUT_LINE_OE; endproperty
  a_idle4: assert property (p_idle4) else $error("out line driven idle");
  property p_one; @(posedge CLK) disable iff (!ARST_N)
    !(SDIO_OE && SERIAL_OUT_LINE_OE); endproperty
  a_one: assert property (p_one) else $error("both pins driven");
  property p_start; @(posedge CLK) disable iff (!ARST_N) s_open |-> s_shut; endproperty
  a_start: assert property (p_start) else $error("drive at frame start");
  property p_instr; @(negedge SCLK) disable iff (CS_N || !ARST_N)
    edges < 8'h10 |-> !SDIO_OE && !SERIAL_OUT_LINE_OE; endproperty
  a_instr: assert property (p_instr) else $error("drive in instruction");
  property p_hold; @(negedge SCLK) disable iff (CS_N || !ARST_N)
    edges > 8'h10 && $past(SDIO_OE) |-> SDIO_OE; endproperty
  a_hold: assert property (p_hold) else $error("pin dropped in frame");
  property p_hold4; @(negedge SCLK) disable iff (CS_N || !ARST_N)
    edges > 8'h10 && $past(SERIAL_OUT_LINE_OE) |-> SERIAL_OUT_LINE_OE; endproperty
  a_hold4: assert property (p_hold4) else $error("out line dropped");
  property p_ftw; @(posedge CLK) disable iff (!ARST_N)
    $changed(FREQUENCY_TUNING_WORD) |-> quiet < 4'h8; endproperty
  a_ftw: assert property (p_ftw) else $error("tuning word moved alone");
endmodule : srap_port_checker

bind srap_port srap_port_checker u_chk (.CLK(CLK), .ARST_N(ARST_N), .SCLK(SCLK),
  .CS_N(CS_N), .SDIO_OE(SDIO_OE), .SERIAL_OUT_LINE_OE(SERIAL_OUT_LINE_OE),
  .FREQUENCY_TUNING_WORD(FREQUENCY_TUNING_WORD));

//--- tb/srap_host.sv
`timescale 1ns/1ps
// host master, mode 0; SCLK stands low outside frames
module srap_host (
  output logic      SCLK,
  output logic      CS_N,
  output wire logic SDIO_IN,
  input  wire logic SDIO_OUT,
  input  wire logic SDIO_OE,
  input  wire logic SERIAL_OUT_LINE,
  input  wire logic SERIAL_OUT_LINE_OE
);
  logic d;
  // shared pin level: the device wins while it drives
  assign SDIO_IN = SDIO_OE ? SDIO_OUT : d;
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    d = 1'b0;
  end
  // one frame of nb rising edges; bits change after falling edges
  task automatic xfer(input logic rd, lsb, input logic [14:0] a, input int nb,
                      input logic [63:0] wd, output logic [63:0] q);
    logic [15:0] w;
    int j;
    int b;
    w = {rd, a};
    q = 64'h0;
    CS_N = 1'b0;
    #32;
    for (int k = 0; k < nb; k++) begin
      j = k - 16;
      b = 8 * (j / 8) + (lsb ? j % 8 : 7 - j % 8);
      if (k < 16) d = lsb ? w[k] : w[15-k];
      else if (!rd) d = wd[b];
      else d = ~d; // released line shows a changing pattern
      #32;
      // bit j was launched on the falling edge after rising edge 16+j; take it as SCLK rises
      if (rd && k >= 16) begin
        q[b] = SDIO_OE ? SDIO_OUT : SERIAL_OUT_LINE_OE ? SERIAL_OUT_LINE : 1'bx;
      end
      SCLK = 1'b1;
      #32 SCLK = 1'b0;
    end
    #32 CS_N = 1'b1;
    #64;
  endtask : xfer
endmodule : srap_host

//--- tb/test_serial_register_access_port.sv
`timescale 1ns/1ps
// host model runs frames; bench checks read data and tuning word
module test_serial_register_access_port;
  logic        clk, arst_n, sclk, cs_n, sdio_in, sdio_out, sdio_oe, sol, sol_oe;
  logic [47:0] frequency_tuning_word;
  logic [63:0] q;
  int          bad_count;
  int          n_checks;

  srap_port DUT (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk), .CS_N(cs_n), .SDIO_IN(sdio_in),
    .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .SERIAL_OUT_LINE(sol),
    .SERIAL_OUT_LINE_OE(sol_oe), .FREQUENCY_TUNING_WORD(frequency_tuning_word));
  srap_host host (.SCLK(sclk), .CS_N(cs_n), .SDIO_IN(sdio_in), .SDIO_OUT(sdio_out),
    .SDIO_OE(sdio_oe), .SERIAL_OUT_LINE(sol), .SERIAL_OUT_LINE_OE(sol_oe));

  // 25 MHz system clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // tuning word compare, zero-extended into the common compare
  task automatic chk_word(input logic [47:0] exp);
    chk({16'h0, frequency_tuning_word}, {16'h0, exp});
  endtask : chk_word
  // whole-byte frames only; partial ones go through host.xfer directly
  task automatic wr(input logic [14:0] a, input int n, input logic [63:0] v, input logic l);
    host.xfer(1'b0, l, a, 16 + 8 * n, v, q);
  endtask : wr
  task automatic rd(input logic [14:0] a, input int n, input logic [63:0] e, input logic l);
    host.xfer(1'b1, l, a, 16 + 8 * n, 64'h0, q);
    chk(q, e);
  endtask : rd
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // test sequence
  initial begin
    bad_count = 0;
    n_checks = 0;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    rd(15'h0000, 1, {56'h0, srap_pkg::CONFIG_RESET}, 1'b0);
    rd(15'h0100, 1, 64'h0, 1'b0);
    $display("defaults done");
    wr(15'h0006, 6, 64'h6655_4433_2211, 1'b0);
    rd(15'h0003, 1, 64'h44, 1'b0);
    chk_word(48'h0);
    wr(srap_pkg::ADDR_LOAD_CTRL, 1, 64'h01, 1'b0);
    repeat (10) @(posedge clk);
    chk_word(48'h1122_3344_5566);
    rd(srap_pkg::ADDR_LOAD_CTRL, 1, 64'h00, 1'b0);
    $display("tuning word done");
    wr(15'h0000, 1, 64'h30, 1'b0);
    rd(15'h0000, 1, 64'h3c, 1'b0);
    rd(15'h0001, 3, 64'h44_5566, 1'b0);
    $display("four wire done");
    wr(15'h0000, 1, 64'h60, 1'b0);
    rd(15'h0000, 1, 64'h66, 1'b1);
    wr(15'h0002, 1, 64'ha5, 1'b1);
    host.xfer(1'b0, 1'b1, 15'h0002, 9, 64'hff, q);
    host.xfer(1'b0, 1'b1, 15'h0002, 20, 64'hff, q);
    rd(15'h0002, 1, 64'ha5, 1'b1);
    $display("lsb first done");
    wr(15'h0000, 1, 64'h81, 1'b1);
    rd(15'h0000, 1, 64'h00, 1'b0);
    rd(15'h0002, 1, 64'h00, 1'b0);
    chk_word(48'h1122_3344_5566);
    $display("soft reset done");
    complete_run();
  end

  // hang guard, far beyond the eighteen frames above
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
endmodule : test_serial_register_access_port
